// ===== verilog/fifo_start_read_pkg.sv
// constants, field layouts and state codes for the block FIFO
package fifo_start_read_pkg;

  // ----------------------------------------------------------------
  // storage geometry
  // ----------------------------------------------------------------
  localparam int FIFO_WIDTH = 10;
  localparam int FIFO_DEPTH = 15;
  localparam int PTR_W = 4;
  localparam int OCC_W = 4;

  // ----------------------------------------------------------------
  // start-read thresholds, in occupied locations
  // ----------------------------------------------------------------
  localparam logic [OCC_W-1:0] STRD_ON_LEVEL = 4'h5;
  localparam logic [OCC_W-1:0] STRD_OFF_LEVEL = 4'h6;

  // ----------------------------------------------------------------
  // input synchroniser
  // ----------------------------------------------------------------
  localparam int SYNC_W = 8;
  localparam int SY_GCLK0 = 0;
  localparam int SY_REC = 4;
  localparam int SY_RCLK = 5;
  localparam int SY_GRST = 6;
  localparam int SY_FRST = 7;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_DATA = 4'h8;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int CT_MODE = 0;
  localparam int CT_WSEL = 2;
  localparam int CT_WINV = 5;
  localparam int CT_RINV = 6;
  localparam int CT_WESEL = 7;
  localparam int CT_FSEL = 9;
  localparam int CT_CLEAR = 11;
  localparam logic [11:0] CTRL_RESET = 12'h000;
  localparam logic [2:0] WSEL_RECOVERED = 3'h4;

  // ----------------------------------------------------------------
  // status register fields
  // ----------------------------------------------------------------
  localparam int ST_EMPTY = 0;
  localparam int ST_FULL = 1;
  localparam int ST_STRD = 2;
  localparam int ST_DONE = 3;
  localparam int ST_OCC = 4;
  localparam int ST_MODE = 8;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_BASIC = 2'b00,
    MODE_FIFO = 2'b01,
    MODE_SERDES = 2'b10,
    MODE_FIFO_SERDES = 2'b11
  } op_mode_t;

  typedef enum logic [1:0] {
    SR_WAIT = 2'b00,
    SR_ACTIVE = 2'b01,
    SR_DONE = 2'b10
  } strd_state_t;

  typedef enum logic [1:0] {
    FLAG_FULL = 2'b00,
    FLAG_EMPTY = 2'b01,
    FLAG_STRD = 2'b10
  } flag_sel_t;

endpackage

// ===== verilog/dual_clock_fifo_start_read.sv
// block FIFO with start-read flag, mode select and Wishbone registers
//
// Our own choices: the Wishbone interface to the registers and the register addresses.

// Summary of operation
// [RULE1] fifteen ten-bit words held as a circular queue
// [RULE2] write and read pointers with two comparators give the flags
// [RULE3] write and read clocks are independent, unrelated pins
// [RULE4] write enable, read enable and a FIFO reset control the queue
// [RULE5] empty, full and active-low start-read flags report state
// [RULE6] power-on reset and global reset also clear the FIFO
// [RULE7] read clock and enable are those of the input registers
// [RULE8] words leaving the FIFO are captured in the input registers
// [RULE9] write clock chosen from global clocks or recovered clock
// [RULE10] write enable chosen from local product-term signals
// [RULE11] all actions on rising edge, each clock polarity invertible
// [RULE12] full, empty or start-read selectable onto the flag pin
// [RULE13] start-read is active low and high after FIFO reset
// [RULE14] five words held: start-read goes low at next write edge
// [RULE15] early reads may delay start-read beyond five write clocks
// [RULE16] six words held: start-read high at next write edge
// [RULE17] once released start-read stays high until next FIFO reset
// [RULE18] user logic watches full and empty to avoid over/underflow
// [RULE19] four modes: basic, FIFO, serdes, FIFO with serdes
// [RULE20] basic mode: FIFO off, fabric to output, pins to routing
// [RULE21] deserializer word and recovered clock feed the FIFO write
// [RULE22] empty at no unread words, full at fifteen, from pointers
module dual_clock_fifo_start_read
  import fifo_start_read_pkg::*;
#(
  parameter int DATA_W = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and power-on reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // asynchronous pins: clocks and resets
  input wire logic [3:0] globalClockNet,
  input wire logic recoveredSerialClock,
  input wire logic readClock,
  input wire logic globalReset_n,
  input wire logic fifoReset,
  // asynchronous data
  input wire logic [DATA_W-1:0] pinData,
  input wire logic [DATA_W-1:0] deserWord,
  // same-clock fabric controls
  input wire logic [3:0] productTermCe,
  input wire logic readEnable,
  input wire logic [DATA_W-1:0] fabricData,
  // outputs
  output logic [DATA_W-1:0] routingData,
  output logic [DATA_W-1:0] outputReg,
  output logic emptyFlag,
  output logic fullFlag,
  output logic startReadFlagN,
  output logic flagPin
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // advance a pointer, wrapping after the last location
  function automatic logic [PTR_W:0] ptrInc(input logic [PTR_W:0] p);
    if (p[PTR_W-1:0] == PTR_W'(DEPTH - 1))
      ptrInc = {~p[PTR_W], {PTR_W{1'b0}}};
    else
      ptrInc = {p[PTR_W], p[PTR_W-1:0] + 1'b1};
  endfunction

  // unread words between two pointers
  function automatic logic [OCC_W-1:0] occupancy(
    input logic [PTR_W:0] w,
    input logic [PTR_W:0] r
  );
    if (w[PTR_W] == r[PTR_W])
      occupancy = OCC_W'(w[PTR_W-1:0] - r[PTR_W-1:0]);
    else
      occupancy = OCC_W'(w[PTR_W-1:0] + PTR_W'(DEPTH) - r[PTR_W-1:0]);
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] syncA;
  logic [SYNC_W-1:0] syncB;
  logic [SYNC_W-1:0] syncC;
  logic [SYNC_W-1:0] pinLevel;
  logic [SYNC_W-1:0] next_pinLevel;
  logic [DATA_W-1:0] pinA;
  logic [DATA_W-1:0] pinB;
  logic [DATA_W-1:0] pinC;
  logic [DATA_W-1:0] desA;
  logic [DATA_W-1:0] desB;
  logic [DATA_W-1:0] desC;
  logic [11:0] ctrl;
  logic clearPulse;
  logic wclkPrev;
  logic rclkPrev;
  logic [DATA_W-1:0] mem [DEPTH];
  logic [PTR_W:0] wrPtr;
  logic [PTR_W:0] rdPtr;
  strd_state_t strdState;
  strd_state_t next_strdState;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // three stages; a level counts once the second and third agree,
  // which filters a single metastable sample at the cost of latency
  wire [SYNC_W-1:0] syncIn = {fifoReset, globalReset_n, readClock,
                              recoveredSerialClock, globalClockNet};
  assign next_pinLevel = (syncB & ~(syncB ^ syncC)) |
                         (pinLevel & (syncB ^ syncC));

  // synchroniser chain, resets to idle clocks and released resets
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      syncA <= 8'h40;
      syncB <= 8'h40;
      syncC <= 8'h40;
      pinLevel <= 8'h40;
    end else begin
      syncA <= syncIn;
      syncB <= syncA;
      syncC <= syncB;
      pinLevel <= next_pinLevel;
    end
  end

  // data follows its clock through the same depth of stages
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pinA <= '0;
      pinB <= '0;
      pinC <= '0;
      desA <= '0;
      desB <= '0;
      desC <= '0;
    end else begin
      pinA <= pinData;
      pinB <= pinA;
      pinC <= pinB;
      desA <= deserWord;
      desB <= desA;
      desC <= desB;
    end
  end

  // ----------------------------------------------------------------
  // mode, clock and enable selection
  // ----------------------------------------------------------------
  wire op_mode_t mode = op_mode_t'(ctrl[CT_MODE +: 2]);
  wire fifoOn = (mode == MODE_FIFO) || (mode == MODE_FIFO_SERDES); // [RULE19]
  wire serdesOn = ctrl[CT_MODE + 1]; // [RULE19]
  wire [2:0] wSel = ctrl[CT_WSEL +: 3];
  wire wclkPick = (wSel == WSEL_RECOVERED) ? pinLevel[SY_REC] :
                  (wSel[2] ? 1'b0 : pinLevel[SY_GCLK0 + wSel[1:0]]); // [RULE9]
  wire wclkLevel = wclkPick ^ ctrl[CT_WINV]; // [RULE11]
  wire rclkLevel = pinLevel[SY_RCLK] ^ ctrl[CT_RINV]; // [RULE11]
  // a change of selection can look like an edge; reconfigure idle
  wire wEdge = wclkLevel & ~wclkPrev; // [RULE3] [RULE11]
  wire rEdge = rclkLevel & ~rclkPrev; // [RULE3] [RULE11]
  wire wrEnable = productTermCe[ctrl[CT_WESEL +: 2]]; // [RULE10]
  wire [DATA_W-1:0] wrData = serdesOn ? desC : pinC; // [RULE21]

  // previous clock levels for edge detection
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wclkPrev <= 1'b0;
      rclkPrev <= 1'b0;
    end else begin
      wclkPrev <= wclkLevel;
      rclkPrev <= rclkLevel;
    end
  end

  // ----------------------------------------------------------------
  // queue flags and handshakes
  // ----------------------------------------------------------------
  // global reset, FIFO reset pin or software clear empty the queue
  wire fifoClear = ~pinLevel[SY_GRST] | pinLevel[SY_FRST] |
                   clearPulse; // [RULE4] [RULE6]
  wire ptrSame = wrPtr[PTR_W-1:0] == rdPtr[PTR_W-1:0]; // [RULE2]
  wire isEmpty = ptrSame & (wrPtr[PTR_W] == rdPtr[PTR_W]); // [RULE22]
  wire isFull = ptrSame & (wrPtr[PTR_W] != rdPtr[PTR_W]); // [RULE22]
  // the queue refuses overflow and underflow as a last guard only
  wire doWrite = fifoOn & wEdge & wrEnable & ~isFull; // [RULE4] [RULE18]
  wire doRead = fifoOn & rEdge & readEnable & ~isEmpty; // [RULE7] [RULE18]
  wire [OCC_W-1:0] held = occupancy(wrPtr, rdPtr);

  // pointer counters
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else if (fifoClear) begin
      wrPtr <= '0; // [RULE4]
      rdPtr <= '0;
    end else begin
      if (doWrite)
        wrPtr <= ptrInc(wrPtr); // [RULE1]
      if (doRead)
        rdPtr <= ptrInc(rdPtr); // [RULE1]
    end
  end

  // storage has no reset; pointers alone define the contents
  always_ff @(posedge ref_clk) begin
    if (doWrite)
      mem[wrPtr[PTR_W-1:0]] <= wrData; // [RULE1]
  end

  // ----------------------------------------------------------------
  // start-read sequencing
  // ----------------------------------------------------------------
  // judged on write edges against unread words, so early reads
  // delay both the assertion and the release
  always_comb begin
    next_strdState = strdState;
    case (strdState)
      SR_WAIT: begin
        if (wEdge && fifoOn && held >= STRD_ON_LEVEL)
          next_strdState = SR_ACTIVE; // [RULE14] [RULE15]
      end
      SR_ACTIVE: begin
        if (wEdge && fifoOn && held >= STRD_OFF_LEVEL)
          next_strdState = SR_DONE; // [RULE16]
      end
      SR_DONE: next_strdState = SR_DONE; // [RULE17]
      default: next_strdState = SR_WAIT;
    endcase
  end

  // sequencer state, cleared with the queue
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n)
      strdState <= SR_WAIT;
    else if (fifoClear)
      strdState <= SR_WAIT; // [RULE13]
    else
      strdState <= next_strdState;
  end

  // ----------------------------------------------------------------
  // flag outputs
  // ----------------------------------------------------------------
  wire nextStrdN = (next_strdState != SR_ACTIVE) | fifoClear; // [RULE13]
  wire flag_sel_t fSel = flag_sel_t'(ctrl[CT_FSEL +: 2]);
  wire nextFlagPin = (fSel == FLAG_FULL) ? isFull :
                     (fSel == FLAG_EMPTY) ? isEmpty :
                     (fSel == FLAG_STRD) ? nextStrdN : 1'b0; // [RULE12]

  // flags registered one cycle after the comparators
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      emptyFlag <= 1'b1;
      fullFlag <= 1'b0;
      startReadFlagN <= 1'b1;
      flagPin <= 1'b0;
    end else begin
      emptyFlag <= isEmpty; // [RULE5]
      fullFlag <= isFull; // [RULE5]
      startReadFlagN <= nextStrdN; // [RULE5] [RULE13]
      flagPin <= nextFlagPin; // [RULE12]
    end
  end

  // ----------------------------------------------------------------
  // input and output registers
  // ----------------------------------------------------------------
  // input registers share the read clock and enable in every mode
  wire [DATA_W-1:0] inputSrc = fifoOn ? mem[rdPtr[PTR_W-1:0]] :
                               (serdesOn ? desC : pinC); // [RULE20]
  wire inputLoad = fifoOn ? doRead : (rEdge & readEnable); // [RULE7]

  // routing-pool side and pin side registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      routingData <= '0;
      outputReg <= '0;
    end else begin
      if (inputLoad)
        routingData <= inputSrc; // [RULE8]
      if (mode == MODE_BASIC)
        outputReg <= fabricData; // [RULE20]
    end
  end

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  wire busReq = cyc_i & stb_i & ~ack_o;
  wire ctrlWrite = busReq & we_i & (adr_i == OFS_CTRL);
  wire [11:0] ctrlMask = {{4{sel_i[1]}}, {8{sel_i[0]}}};
  wire [11:0] ctrlNew = (dat_i[11:0] & ctrlMask) | (ctrl & ~ctrlMask);
  wire [31:0] statusWord = {22'h0, mode, held,
                            strdState == SR_DONE, nextStrdN,
                            isFull, isEmpty};
  wire [31:0] readWord = (adr_i == OFS_CTRL) ? {20'h0, ctrl} :
                         (adr_i == OFS_STATUS) ? statusWord :
                         (adr_i == OFS_DATA) ?
                         {{(32-DATA_W){1'b0}}, routingData} : 32'h0;

  // control register; the clear bit never stays stored
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= CTRL_RESET;
      clearPulse <= 1'b0;
    end else begin
      clearPulse <= ctrlWrite & sel_i[1] & dat_i[CT_CLEAR]; // [RULE4]
      if (ctrlWrite)
        ctrl <= ctrlNew & ~(12'h1 << CT_CLEAR); // [RULE19]
    end
  end

  // one-cycle acknowledge, unmapped reads answer zero
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end else begin
      ack_o <= busReq;
      if (busReq && !we_i)
        dat_o <= readWord;
    end
  end

endmodule

// ===== tb/fifo_start_read_sva.sv
// assertion checker for the block FIFO, bound to its top module
module fifo_start_read_sva
  import fifo_start_read_pkg::*;
#(
  parameter int DATA_W = FIFO_WIDTH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // register bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic ack_o,
  // resets and fabric data
  input wire logic globalReset_n,
  input wire logic fifoReset,
  input wire logic [DATA_W-1:0] fabricData,
  // watched outputs
  input wire logic [DATA_W-1:0] outputReg,
  input wire logic emptyFlag,
  input wire logic fullFlag,
  input wire logic startReadFlagN,
  input wire logic flagPin
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // shadow of control fields, one edge behind the design's copy
  // ----------------------------------------------------------------
  logic [1:0] fsel;
  logic [1:0] mode;
  wire logic ctrlWr = cyc_i && stb_i && we_i && ack_o && adr_i == OFS_CTRL;
  wire logic selFlag = fsel == 2'h0 ? fullFlag : fsel == 2'h1 ? emptyFlag :
    fsel == 2'h2 ? startReadFlagN : 1'h0;
  // lag is harmless: every use waits for the shadow to be stable
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fsel <= 2'h0;
      mode <= 2'h0;
    end else if (ctrlWr) begin
      fsel <= dat_i[CT_FSEL+:2];
      mode <= dat_i[CT_MODE+:2];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // properties
  property p_ack_next; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("ack missing after request");
  property p_rst_flags;
    $rose(arst_n) |-> emptyFlag && !fullFlag && startReadFlagN;
  endproperty
  a_rst_flags: assert property (p_rst_flags)
    else $error("flags wrong after reset");
  property p_strd_fall; $fell(startReadFlagN) |-> !emptyFlag; endproperty
  a_strd_fall: assert property (p_strd_fall)
    else $error("start-read low on empty queue");
  property p_flag_pin;
    ($stable(fsel) && $stable(selFlag)) [*3] |-> flagPin == selFlag;
  endproperty
  a_flag_pin: assert property (p_flag_pin)
    else $error("flag pin not the selected flag");
  property p_basic_out;
    mode == 2'h0 && $stable(mode) |=> outputReg == $past(fabricData);
  endproperty
  a_basic_out: assert property (p_basic_out)
    else $error("output register not following fabric");
  property p_other_hold;
    mode != 2'h0 && $stable(mode) |=> $stable(outputReg);
  endproperty
  a_other_hold: assert property (p_other_hold)
    else $error("output register moved outside basic mode");
  property p_clear;
    ctrlWr && dat_i[CT_CLEAR] |-> ##2 emptyFlag && startReadFlagN;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear did not empty queue");
  property p_grst;
    $fell(globalReset_n) |-> ##[1:10] emptyFlag && startReadFlagN;
  endproperty
  a_grst: assert property (p_grst)
    else $error("global reset did not empty queue");
  property p_frst;
    $rose(fifoReset) |-> ##[1:10] emptyFlag && startReadFlagN;
  endproperty
  a_frst: assert property (p_frst)
    else $error("queue reset did not empty queue");
  c_strd_low: cover property ($fell(startReadFlagN));
  c_full: cover property ($rose(fullFlag));
  c_strd_done: cover property ($rose(startReadFlagN) && !emptyFlag);
endmodule

bind dual_clock_fifo_start_read fifo_start_read_sva #(.DATA_W(DATA_W))
  u_fifo_start_read_sva (
  .ref_clk(ref_clk), .arst_n(arst_n), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .ack_o(ack_o),
  .globalReset_n(globalReset_n), .fifoReset(fifoReset),
  .fabricData(fabricData), .outputReg(outputReg), .emptyFlag(emptyFlag),
  .fullFlag(fullFlag), .startReadFlagN(startReadFlagN), .flagPin(flagPin)
);

// ===== tb/word_source.sv
// writing partner: a source that drives write clock and word pins
module word_source (
  // bench clock
  input wire logic ref_clk,
  // write side pins
  output logic wrClk,
  output logic [9:0] wrData
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    wrClk = 1'h0;
    wrData = 10'h2AA;
  end
  // one rising write edge per word, held low outside words
  // stale data is inverted so it never passes for the fresh word
  task automatic push(input logic [9:0] w, input int hold);
    @(posedge ref_clk) wrData <= w;
    repeat (6) @(posedge ref_clk);
    wrClk <= 1'h1;
    repeat (hold) @(posedge ref_clk);
    wrClk <= 1'h0;
    repeat (hold) @(posedge ref_clk);
    wrData <= ~w;
  endtask
endmodule

// ===== tb/dual_clock_fifo_start_read_bench.sv
// self-checking bench for the block FIFO with start-read flag
module dual_clock_fifo_start_read_bench;
  import fifo_start_read_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // stimulus, partner and design
  // ----------------------------------------------------------------
  logic ref_clk = 1'h0;
  logic arst_n = 1'h0;
  logic cyc_i = 1'h0;
  logic stb_i = 1'h0;
  logic we_i = 1'h0;
  logic [3:0] adr_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic readClock = 1'h0;
  logic globalReset_n = 1'h1;
  logic fifoReset = 1'h0;
  logic [3:0] productTermCe = 4'h0;
  logic readEnable = 1'h1;
  logic [9:0] fabricData = 10'h000;
  logic route = 1'h0;
  logic [31:0] q;
  logic [31:0] dat_o;
  logic ack_o, emptyFlag, fullFlag, startReadFlagN, flagPin;
  logic [9:0] routingData, outputReg;
  int failures = 0;
  int checkCount = 0;
  int cycles = 0;
  wire logic wrClk;
  wire logic [9:0] wrData;
  // route picks global net 0 or the recovered clock for the writer
  wire logic [3:0] globalClockNet = route ? 4'h0 : {3'h0, wrClk};
  wire logic recoveredSerialClock = route & wrClk;
  wire logic [9:0] deserWord = ~wrData;
  always #25 ref_clk = ~ref_clk;
  word_source u_word_source (.ref_clk(ref_clk), .wrClk(wrClk),
    .wrData(wrData));
  dual_clock_fifo_start_read u_dual_clock_fifo_start_read (
    .ref_clk(ref_clk), .arst_n(arst_n), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .globalClockNet(globalClockNet),
    .recoveredSerialClock(recoveredSerialClock), .readClock(readClock),
    .globalReset_n(globalReset_n), .fifoReset(fifoReset),
    .pinData(wrData), .deserWord(deserWord), .productTermCe(productTermCe),
    .readEnable(readEnable), .fabricData(fabricData),
    .routingData(routingData), .outputReg(outputReg),
    .emptyFlag(emptyFlag), .fullFlag(fullFlag),
    .startReadFlagN(startReadFlagN), .flagPin(flagPin));
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checkCount++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // classic single cycle, held until ack, read data kept in q
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge ref_clk); while (ack_o !== 1'h1);
    q = dat_o;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
  endtask
  // odd words use the slow writer, to vary clock high and low times
  task automatic wr(input logic [9:0] w);
    u_word_source.push(w, w[0] ? 6 : 3);
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic rd();
    @(posedge ref_clk) readClock <= 1'h1;
    repeat (4) @(posedge ref_clk);
    readClock <= 1'h0;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // a hung wait ends here as a mismatch
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  // main sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'h1;
    repeat (6) @(posedge ref_clk);
    chk("emptyFlag", emptyFlag, 1'h1);
    chk("startReadFlagN", startReadFlagN, 1'h1);
    wb(1'h0, OFS_CTRL, 32'h0);
    chk("ctrl", q, CTRL_RESET);
    wb(1'h0, 4'hC, 32'h0);
    chk("unmapped", q, 32'h0);
    fabricData <= 10'h155;
    rd();
    chk("outputReg", outputReg, 10'h155);
    chk("routingData", routingData, 10'h2AA);
    for (int f = 0; f < 4; f++) begin
      wb(1'h1, OFS_CTRL, 32'h1 | (f << 9));
      repeat (3) @(posedge ref_clk);
      chk("flagPin", flagPin, f == 1 || f == 2);
    end
    wr(10'h3C3);
    chk("emptyFlag", emptyFlag, 1'h1);
    productTermCe <= 4'h1;
    // writer stops at fifteen words
    for (int k = 1; k <= 15; k++) begin
      wr(10'(k) + 10'h100);
      chk("startReadFlagN", startReadFlagN, k != 6);
    end
    chk("fullFlag", fullFlag, 1'h1);
    wb(1'h0, OFS_STATUS, 32'h0);
    chk("status", q[7:0], 8'hFE);
    readEnable <= 1'h0;
    rd();
    chk("fullFlag", fullFlag, 1'h1);
    readEnable <= 1'h1;
    for (int k = 1; k <= 15; k++) begin
      rd();
      chk("routingData", routingData, 10'(k) + 10'h100);
    end
    chk("emptyFlag", emptyFlag, 1'h1);
    repeat (6) wr(10'h0C3);
    chk("startReadFlagN", startReadFlagN, 1'h1);
    // bus clear, queue reset pin, global reset pin in turn
    for (int s = 0; s < 3; s++) begin
      repeat (3) wr(10'h0AA);
      if (s == 0) wb(1'h1, OFS_CTRL, 32'h801);
      if (s == 1) fifoReset <= 1'h1;
      if (s == 2) globalReset_n <= 1'h0;
      repeat (10) @(posedge ref_clk);
      fifoReset <= 1'h0;
      globalReset_n <= 1'h1;
      repeat (6) @(posedge ref_clk);
      chk("emptyFlag", emptyFlag, 1'h1);
    end
    repeat (6) wr(10'h055);
    chk("startReadFlagN", startReadFlagN, 1'h0);
    route <= 1'h1;
    wb(1'h1, OFS_CTRL, 32'h813);
    wr(10'h0F0);
    rd();
    chk("routingData", routingData, 10'h30F);
    // serdes only: no queue, input register takes the deserializer word
    wb(1'h1, OFS_CTRL, 32'h2);
    rd();
    chk("routingData", routingData, 10'h0F0);
    tally_and_finish();
  end
endmodule
